// file: core/pcg_device.sv
// Power management end: module clock disable maps and low-power entry and wake
`timescale 1ns/10ps
module pcg_device (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  pcg_if.dev bus,
  output logic [pcg_pkg::PCG_SLOTS-1:0] o_slot_clk_en,
  output logic [pcg_pkg::PCG_SLOTS-1:0] o_slot_reg_en,
  output logic o_core_clk_en,
  output logic o_exit_lp_req,
  output pcg_pkg::pcg_lpmode_t o_lp_mode
);
  import pcg_pkg::*;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [PCG_SLOTS-1:0] dis_q;
  logic [PCG_SLOTS-1:0] dis_d;
  logic [7:0] wake_q;
  logic [7:0] wake_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic rsp_valid_q;
  logic rsp_valid_d;
  logic [PCG_DATA_W-1:0] rsp_rdata_q;
  logic [PCG_DATA_W-1:0] rsp_rdata_d;
  logic [PCG_SLOTS-1:0] clk_en_q;
  logic [PCG_SLOTS-1:0] clk_en_d;
  logic [PCG_SLOTS-1:0] reg_en_q;
  logic [PCG_SLOTS-1:0] reg_en_d;

  function automatic logic word_hit(input logic [PCG_ADDR_W-1:0] a,
                                    input logic [PCG_ADDR_W-1:0] off);
    return a[PCG_ADDR_W-1:2] == off[PCG_ADDR_W-1:2];
  endfunction

  logic wr;
  logic rd;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  assign wr = bus.req_valid && bus.req_write;
  assign rd = bus.req_valid && !bus.req_write;
  assign set_v = bus.req_wdata[8*LANE_SET +: 8];
  assign clr_v = bus.req_wdata[8*LANE_CLR +: 8];

  always_comb begin
    dis_d = dis_q;
    wake_d = wake_q;
    mode_d = mode_q;
    if (wr && word_hit(bus.req_addr, OFF_DIS_LOW)) begin
      for (int k = 0; k < PCG_LANES; k++) begin
        if (bus.req_be[k]) begin
          dis_d[8*k +: 8] = bus.req_wdata[8*k +: 8];
        end
      end
    end
    if (wr && word_hit(bus.req_addr, OFF_DIS_HIGH)) begin
      for (int k = 0; k < PCG_LANES; k++) begin
        if (bus.req_be[k]) begin
          dis_d[PCG_MAP_W + 8*k +: 8] = bus.req_wdata[8*k +: 8];
        end
      end
    end
    if (wr && word_hit(bus.req_addr, OFF_WAKE_CTRL) && bus.req_be[LANE_WAKE]) begin
      wake_d = bus.req_wdata[8*LANE_WAKE +: 8] & WAKE_CTRL_MASK;
    end
    if (wr && word_hit(bus.req_addr, OFF_MODE_CTRL) && bus.req_be[LANE_MODE]) begin
      mode_d = bus.req_wdata[8*LANE_MODE +: 8] & MODE_CTRL_MASK;
    end
    if (wr && word_hit(bus.req_addr, OFF_DIS_SET) && bus.req_be[LANE_SET]) begin
      if (set_v[SC_ALL_BIT]) begin
        dis_d = '1;
      end else begin
        dis_d[set_v[SC_IDX_W-1:0]] = 1'b1;
      end
    end
    // Clear applied last so it overrides a set in the same access
    if (wr && word_hit(bus.req_addr, OFF_DIS_CLR) && bus.req_be[LANE_CLR]) begin
      if (clr_v[SC_ALL_BIT]) begin
        dis_d = '0;
      end else begin
        dis_d[clr_v[SC_IDX_W-1:0]] = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read data and slot enables
  // ****************************************************************
  always_comb begin
    rsp_valid_d = bus.req_valid;
    rsp_rdata_d = '0;
    if (rd) begin
      if (word_hit(bus.req_addr, OFF_DIS_LOW)) begin
        rsp_rdata_d = dis_q[PCG_MAP_W-1:0];
      end else if (word_hit(bus.req_addr, OFF_DIS_HIGH)) begin
        rsp_rdata_d = dis_q[PCG_SLOTS-1:PCG_MAP_W];
      end else if (word_hit(bus.req_addr, OFF_WAKE_CTRL)) begin
        rsp_rdata_d[8*LANE_WAKE +: 8] = wake_q;
      end else if (word_hit(bus.req_addr, OFF_MODE_CTRL)) begin
        rsp_rdata_d[8*LANE_MODE +: 8] = mode_q;
      end
    end
    clk_en_d = ~dis_d | ALWAYS_ON_MASK;
    reg_en_d = dis_d[SLOT_GLOBAL] ? REG_EXEMPT_MASK : '1;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dis_q <= {RST_DIS_HIGH, RST_DIS_LOW};
      wake_q <= RST_WAKE_CTRL;
      mode_q <= RST_MODE_CTRL;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      clk_en_q <= ~{RST_DIS_HIGH, RST_DIS_LOW} | ALWAYS_ON_MASK;
      reg_en_q <= '1;
    end else begin
      dis_q <= dis_d;
      wake_q <= wake_d;
      mode_q <= mode_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_rdata_q <= rsp_rdata_d;
      clk_en_q <= clk_en_d;
      reg_en_q <= reg_en_d;
    end
  end

  // ****************************************************************
  // Low-power entry and wake
  // ****************************************************************
  pcg_state_t state_q;
  pcg_state_t state_d;
  pcg_lpmode_t lpm_q;
  pcg_lpmode_t lpm_d;
  logic core_en_q;
  logic core_en_d;
  logic exit_q;
  logic exit_d;
  logic stop_seen_q;
  logic stop_seen_d;

  pcg_lpmode_t sel_mode;
  logic stop_edge;
  logic enter;
  logic [WC_THR_W-1:0] thr;
  logic [WC_THR_W-1:0] min_level;
  logic wake_hit;

  assign sel_mode = pcg_lpmode_t'(mode_q[MC_MODE_LSB +: 2]);
  assign stop_edge = (bus.processor_status_code == PSC_STOP) && !stop_seen_q;
  // Stop select without stop enable leaves clocks running
  assign enter = stop_edge && (sel_mode != PCG_MODE_RUN) &&
                 !(sel_mode == PCG_MODE_STOP && !wake_q[WC_STOP_EN_BIT]);
  assign thr = wake_q[WC_THR_LSB +: WC_THR_W];
  assign min_level = (thr > THR_CAP) ? THR_CAP : thr;
  // Evaluated straight from the request inputs while gated
  assign wake_hit = (bus.irq_level > min_level) &&
                    (lpm_q != PCG_MODE_STOP || bus.irq_fixed);

  always_comb begin
    state_d = state_q;
    lpm_d = lpm_q;
    core_en_d = core_en_q;
    exit_d = 1'b0;
    stop_seen_d = (bus.processor_status_code == PSC_STOP);
    unique case (state_q)
      PCG_ST_RUN: begin
        if (enter) begin
          state_d = PCG_ST_LOW;
          lpm_d = sel_mode;
          core_en_d = 1'b0;
        end
      end
      PCG_ST_LOW: begin
        if (wake_hit) begin
          state_d = PCG_ST_EXIT;
          exit_d = 1'b1;
        end
      end
      PCG_ST_EXIT: begin
        state_d = PCG_ST_RUN;
        lpm_d = PCG_MODE_RUN;
        core_en_d = 1'b1;
      end
      default: begin
        state_d = PCG_ST_RUN;
        lpm_d = PCG_MODE_RUN;
        core_en_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= PCG_ST_RUN;
      lpm_q <= PCG_MODE_RUN;
      core_en_q <= 1'b1;
      exit_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lpm_q <= lpm_d;
      core_en_q <= core_en_d;
      exit_q <= exit_d;
      stop_seen_q <= stop_seen_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.rsp_valid = rsp_valid_q;
  assign bus.rsp_rdata = rsp_rdata_q;
  assign bus.core_clk_en = core_en_q;
  assign bus.exit_lp_req = exit_q;
  assign bus.lp_mode = lpm_q;
  assign o_slot_clk_en = clk_en_q;
  assign o_slot_reg_en = reg_en_q;
  assign o_core_clk_en = core_en_q;
  assign o_exit_lp_req = exit_q;
  assign o_lp_mode = lpm_q;

endmodule

// file: core/pcg_host.sv
// Processor-side end: register accesses, stop status code and interrupt requests
`timescale 1ns/10ps
module pcg_host (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  pcg_if.host bus,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [pcg_pkg::PCG_ADDR_W-1:0] i_cmd_addr,
  input wire logic [pcg_pkg::PCG_LANES-1:0] i_cmd_be,
  input wire logic [pcg_pkg::PCG_DATA_W-1:0] i_cmd_wdata,
  input wire logic i_stop_exec,
  input wire logic [pcg_pkg::IRQ_W-1:0] i_irq_level,
  input wire logic i_irq_fixed,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [pcg_pkg::PCG_DATA_W-1:0] o_rsp_rdata,
  output logic o_core_clk_en,
  output logic o_exit_seen
);
  import pcg_pkg::*;

  // ****************************************************************
  // Register access, one outstanding
  // ****************************************************************
  logic busy_q;
  logic busy_d;
  logic req_valid_q;
  logic req_valid_d;
  logic req_write_q;
  logic req_write_d;
  logic [PCG_ADDR_W-1:0] req_addr_q;
  logic [PCG_ADDR_W-1:0] req_addr_d;
  logic [PCG_LANES-1:0] req_be_q;
  logic [PCG_LANES-1:0] req_be_d;
  logic [PCG_DATA_W-1:0] req_wdata_q;
  logic [PCG_DATA_W-1:0] req_wdata_d;
  logic rsp_valid_q;
  logic [PCG_DATA_W-1:0] rsp_rdata_q;
  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] psc_d;
  logic [IRQ_W-1:0] irq_q;
  logic irq_fixed_q;
  logic core_en_q;
  logic exit_seen_q;

  always_comb begin
    busy_d = busy_q;
    req_valid_d = 1'b0;
    req_write_d = req_write_q;
    req_addr_d = req_addr_q;
    req_be_d = req_be_q;
    req_wdata_d = req_wdata_q;
    if (i_cmd_valid && !busy_q) begin
      busy_d = 1'b1;
      req_valid_d = 1'b1;
      req_write_d = i_cmd_write;
      req_addr_d = i_cmd_addr;
      req_be_d = i_cmd_be;
      req_wdata_d = i_cmd_wdata;
    end else if (bus.rsp_valid) begin
      busy_d = 1'b0;
    end
    // Status code held while the core sits stopped
    psc_d = i_stop_exec ? PSC_STOP : PSC_RUN;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      req_valid_q <= 1'b0;
      req_write_q <= 1'b0;
      req_addr_q <= '0;
      req_be_q <= '0;
      req_wdata_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      psc_q <= PSC_RUN;
      irq_q <= '0;
      irq_fixed_q <= 1'b0;
      core_en_q <= 1'b1;
      exit_seen_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      req_valid_q <= req_valid_d;
      req_write_q <= req_write_d;
      req_addr_q <= req_addr_d;
      req_be_q <= req_be_d;
      req_wdata_q <= req_wdata_d;
      rsp_valid_q <= bus.rsp_valid;
      rsp_rdata_q <= bus.rsp_rdata;
      psc_q <= psc_d;
      irq_q <= i_irq_level;
      irq_fixed_q <= i_irq_fixed;
      core_en_q <= bus.core_clk_en;
      exit_seen_q <= bus.exit_lp_req;
    end
  end

  assign bus.req_valid = req_valid_q;
  assign bus.req_write = req_write_q;
  assign bus.req_addr = req_addr_q;
  assign bus.req_be = req_be_q;
  assign bus.req_wdata = req_wdata_q;
  assign bus.processor_status_code = psc_q;
  assign bus.irq_level = irq_q;
  assign bus.irq_fixed = irq_fixed_q;
  assign o_cmd_ready = !busy_q;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_rdata = rsp_rdata_q;
  assign o_core_clk_en = core_en_q;
  assign o_exit_seen = exit_seen_q;

endmodule

// file: shared/pcg_if.sv
// Interface joining the power management block and its processor-side partner
`timescale 1ns/10ps
interface pcg_if;
  import pcg_pkg::*;

  logic req_valid;
  logic req_write;
  logic [PCG_ADDR_W-1:0] req_addr;
  logic [PCG_LANES-1:0] req_be;
  logic [PCG_DATA_W-1:0] req_wdata;
  logic rsp_valid;
  logic [PCG_DATA_W-1:0] rsp_rdata;
  logic [PSC_W-1:0] processor_status_code;
  logic [IRQ_W-1:0] irq_level;
  logic irq_fixed;
  logic core_clk_en;
  logic exit_lp_req;
  pcg_lpmode_t lp_mode;

  modport dev (
    input req_valid, req_write, req_addr, req_be, req_wdata,
    input processor_status_code, irq_level, irq_fixed,
    output rsp_valid, rsp_rdata, core_clk_en, exit_lp_req, lp_mode
  );

  modport host (
    output req_valid, req_write, req_addr, req_be, req_wdata,
    output processor_status_code, irq_level, irq_fixed,
    input rsp_valid, rsp_rdata, core_clk_en, exit_lp_req, lp_mode
  );

endinterface

// file: shared/pcg_pkg.sv
// Shared constants and types for the peripheral clock gating and low-power wake block
package pcg_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int PCG_ADDR_W = 24;
  localparam int PCG_DATA_W = 32;
  localparam int PCG_LANES = 4;
  localparam int PCG_SLOTS = 64;
  localparam int PCG_MAP_W = 32;

  // ****************************************************************
  // Register offsets (byte addresses, big-endian lanes)
  // ****************************************************************
  localparam logic [23:0] OFF_DIS_HIGH = 24'h00000C;
  localparam logic [23:0] OFF_WAKE_CTRL = 24'h000012;
  localparam logic [23:0] OFF_DIS_LOW = 24'h000018;
  localparam logic [23:0] OFF_DIS_SET = 24'h000021;
  localparam logic [23:0] OFF_DIS_CLR = 24'h000022;
  localparam logic [23:0] OFF_MODE_CTRL = 24'h110007;

  // Byte at offset o sits on lane 3 - o[1:0], bits [8*lane+7:8*lane]
  localparam int LANE_WAKE = 3 - int'(OFF_WAKE_CTRL[1:0]);
  localparam int LANE_SET = 3 - int'(OFF_DIS_SET[1:0]);
  localparam int LANE_CLR = 3 - int'(OFF_DIS_CLR[1:0]);
  localparam int LANE_MODE = 3 - int'(OFF_MODE_CTRL[1:0]);

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [31:0] RST_DIS_LOW = 32'h0040_0004;
  localparam logic [31:0] RST_DIS_HIGH = 32'h0000_0000;
  localparam logic [7:0] RST_WAKE_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] WAKE_CTRL_MASK = 8'hF0;
  localparam logic [7:0] MODE_CTRL_MASK = 8'hDA;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int WC_STOP_EN_BIT = 7;
  localparam int WC_THR_LSB = 4;
  localparam int WC_THR_W = 3;
  localparam int MC_MODE_LSB = 6;
  localparam int SC_ALL_BIT = 6;
  localparam int SC_IDX_W = 6;
  localparam logic [2:0] THR_CAP = 3'h6;

  // ****************************************************************
  // Slot assignments
  // ****************************************************************
  localparam int SLOT_GLOBAL = 1;
  // Bus controller (0), global space (1), system control (8) never stop
  localparam logic [63:0] ALWAYS_ON_MASK = 64'h0000_0000_0000_0103;
  // RTC (46) and USB (24) keep register access under the global block
  localparam logic [63:0] REG_EXEMPT_MASK = 64'h0000_4000_0100_0000;

  // ****************************************************************
  // Processor status and interrupt level
  // ****************************************************************
  localparam int PSC_W = 4;
  localparam logic [3:0] PSC_RUN = 4'h0;
  localparam logic [3:0] PSC_STOP = 4'hE;
  localparam int IRQ_W = 3;

  typedef enum logic [1:0] {
    PCG_MODE_RUN = 2'b00,
    PCG_MODE_DOZE = 2'b01,
    PCG_MODE_WAIT = 2'b10,
    PCG_MODE_STOP = 2'b11
  } pcg_lpmode_t;

  typedef enum logic [1:0] {
    PCG_ST_RUN = 2'b00,
    PCG_ST_LOW = 2'b01,
    PCG_ST_EXIT = 2'b10
  } pcg_state_t;

endpackage

// file: test/pcg_link_asserts.sv
// Assertions on the link between the power management end and the processor end
`timescale 1ns/10ps
module pcg_link_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [pcg_pkg::PCG_ADDR_W-1:0] req_addr,
  input wire logic rsp_valid,
  input wire logic [pcg_pkg::PCG_DATA_W-1:0] rsp_rdata,
  input wire logic [pcg_pkg::PSC_W-1:0] processor_status_code,
  input wire logic [pcg_pkg::IRQ_W-1:0] irq_level,
  input wire logic irq_fixed,
  input wire logic core_clk_en,
  input wire logic exit_lp_req,
  input wire pcg_pkg::pcg_lpmode_t lp_mode
);
  import pcg_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence low_s;
    !core_clk_en && !exit_lp_req;
  endsequence
  sequence exit_s;
    exit_lp_req ##1 (core_clk_en && lp_mode == PCG_MODE_RUN && !exit_lp_req);
  endsequence
  rsp_follow_a: assert property (req_valid |=> rsp_valid)
    else $error("no answer after request");
  rsp_only_a: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  setclr_zero_a: assert property (
    req_valid && !req_write && req_addr[23:2] == 22'h000008 |=> rsp_rdata == 32'h0)
    else $error("set or clear word read not zero");
  entry_cause_a: assert property (
    $fell(core_clk_en) |-> $past(processor_status_code) == PSC_STOP && lp_mode != PCG_MODE_RUN)
    else $error("core clock gated without stop code");
  mode_gate_a: assert property (core_clk_en == (lp_mode == PCG_MODE_RUN))
    else $error("core clock and mode disagree");
  exit_seq_a: assert property (exit_lp_req |-> exit_s)
    else $error("clocks not restored after exit");
  exit_cause_a: assert property (
    exit_lp_req |-> !$past(core_clk_en) && $past(irq_level) != 3'h0)
    else $error("exit without request while low");
  stop_fixed_a: assert property (
    exit_lp_req && lp_mode == PCG_MODE_STOP |-> $past(irq_fixed))
    else $error("stop left without fixed request");
  no_wake_a: assert property (low_s ##0 irq_level == 3'h0 |=> !exit_lp_req)
    else $error("exit with no request");
  low_hold_a: assert property (low_s |=> $stable(lp_mode))
    else $error("mode changed while low");
endmodule

// file: test/test_peripheral_clock_gating_low_power_wake.sv
// Self-checking bench for both ends of the clock gating and wake link
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] %s exp %h seen %h", n, e, g); end end
module test_peripheral_clock_gating_low_power_wake;
  import pcg_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [23:0] cmd_addr = 24'h000000;
  logic [3:0] cmd_be = 4'h0;
  logic [31:0] cmd_wdata = 32'h0;
  logic stop_exec = 1'b0;
  logic [2:0] irq_level = 3'h0;
  logic irq_fixed = 1'b0;
  logic cmd_ready;
  logic rsp_valid;
  logic core_clk_en;
  logic [31:0] rsp_rdata;
  logic [31:0] rd;
  logic [2:0] thr;
  logic [63:0] slot_clk_en;
  logic [63:0] slot_reg_en;
  pcg_lpmode_t lp_mode;
  logic exit_req;
  logic exit_seen;
  logic host_core_en;
  int exit_cnt = 0;
  int seen_cnt = 0;
  int error_cnt = 0;
  int num_checks = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  // Exit pulses on both ends, one count per high cycle
  always @(posedge i_ref_clk) begin
    if (exit_req === 1'b1) begin
      exit_cnt++;
    end
    if (exit_seen === 1'b1) begin
      seen_cnt++;
    end
  end
  // ****************************************************************
  // Both ends and the checker
  // ****************************************************************
  pcg_if pcg_if_i ();
  pcg_device pcg_device_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(pcg_if_i),
    .o_slot_clk_en(slot_clk_en), .o_slot_reg_en(slot_reg_en), .o_core_clk_en(core_clk_en),
    .o_exit_lp_req(exit_req), .o_lp_mode(lp_mode));
  pcg_host pcg_host_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(pcg_if_i),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
    .i_cmd_be(cmd_be), .i_cmd_wdata(cmd_wdata), .i_stop_exec(stop_exec),
    .i_irq_level(irq_level), .i_irq_fixed(irq_fixed), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata), .o_core_clk_en(host_core_en),
    .o_exit_seen(exit_seen));
  pcg_link_asserts pcg_link_asserts_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .req_valid(pcg_if_i.req_valid), .req_write(pcg_if_i.req_write),
    .req_addr(pcg_if_i.req_addr), .rsp_valid(pcg_if_i.rsp_valid),
    .rsp_rdata(pcg_if_i.rsp_rdata), .processor_status_code(pcg_if_i.processor_status_code),
    .irq_level(pcg_if_i.irq_level), .irq_fixed(pcg_if_i.irq_fixed),
    .core_clk_en(pcg_if_i.core_clk_en), .exit_lp_req(pcg_if_i.exit_lp_req),
    .lp_mode(pcg_if_i.lp_mode));
  // ****************************************************************
  // Access and wait tasks
  // ****************************************************************
  task automatic acc(input logic w, input logic [23:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_be = be;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge i_ref_clk);
      n++;
    end
    @(negedge i_ref_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge i_ref_clk);
      n++;
    end
    rd = rsp_rdata;
    `CHK("rsp valid", 1'b1, rsp_valid)
  endtask
  task automatic wt(input logic e);
    repeat (10) if (core_clk_en !== e) @(negedge i_ref_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (8) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    acc(1'b0, OFF_DIS_LOW, 4'hF, 32'h0);
    `CHK("low map", 32'h0040_0004, rd)
    acc(1'b0, OFF_DIS_HIGH, 4'hF, 32'h0);
    `CHK("high map", 32'h0, rd)
    acc(1'b0, OFF_WAKE_CTRL, 4'h2, 32'h0);
    `CHK("wake ctrl", 32'h0, rd)
    `CHK("slot clk", ~64'h0040_0004 | ALWAYS_ON_MASK, slot_clk_en)
    `CHK("slot reg", ~64'h0, slot_reg_en)
    $display("reset test done");
    acc(1'b1, OFF_DIS_LOW, 4'hF, 32'hFFFF_FFFF);
    `CHK("slot clk", ALWAYS_ON_MASK | 64'hFFFF_FFFF_0000_0000, slot_clk_en)
    `CHK("slot reg", REG_EXEMPT_MASK, slot_reg_en)
    acc(1'b1, OFF_DIS_LOW, 4'h1, 32'h0);
    acc(1'b0, OFF_DIS_LOW, 4'hF, 32'h0);
    `CHK("low map", 32'hFFFF_FF00, rd)
    acc(1'b0, 24'h000030, 4'hF, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    acc(1'b0, OFF_DIS_SET, 4'h4, 32'h0);
    `CHK("set reg", 32'h0, rd)
    acc(1'b1, OFF_MODE_CTRL, 4'h1, 32'hFFFF_FFFF);
    acc(1'b0, OFF_MODE_CTRL, 4'h1, 32'h0);
    `CHK("mode ctrl", 32'h0000_00DA, rd)
    acc(1'b1, OFF_WAKE_CTRL, 4'h2, 32'hFFFF_FFFF);
    acc(1'b0, OFF_WAKE_CTRL, 4'h2, 32'h0);
    `CHK("wake ctrl", 32'h0000_F000, rd)
    $display("register test done");
    acc(1'b1, OFF_DIS_CLR, 4'h2, 32'h0000_4000);
    acc(1'b0, OFF_DIS_LOW, 4'hF, 32'h0);
    `CHK("low map", 32'h0, rd)
    acc(1'b1, OFF_DIS_SET, 4'h4, 32'h002E_0000);
    acc(1'b0, OFF_DIS_HIGH, 4'hF, 32'h0);
    `CHK("high map", 32'h0000_4000, rd)
    `CHK("slot clk", ~64'h0000_4000_0000_0000, slot_clk_en)
    acc(1'b1, OFF_DIS_SET, 4'h4, 32'h00FF_0000);
    acc(1'b0, OFF_DIS_LOW, 4'hF, 32'h0);
    `CHK("low map", 32'hFFFF_FFFF, rd)
    acc(1'b1, 24'h000020, 4'h6, 32'h0011_1100);
    acc(1'b0, OFF_DIS_LOW, 4'hF, 32'h0);
    `CHK("low map", 32'hFFFD_FFFF, rd)
    `CHK("slot clk", ALWAYS_ON_MASK | 64'h0000_0000_0002_0000, slot_clk_en)
    acc(1'b1, OFF_DIS_CLR, 4'h2, 32'h0000_C000);
    `CHK("slot clk", ~64'h0, slot_clk_en)
    acc(1'b1, OFF_DIS_SET, 4'h4, 32'h0005_0000);
    `CHK("slot clk", ~64'h0000_0000_0000_0020, slot_clk_en)
    $display("set clear test done");
    for (int c = 0; c < 8; c++) begin
      thr = (c > 5) ? 3'h6 : c[2:0];
      acc(1'b1, OFF_WAKE_CTRL, 4'h2, {16'h0000, 1'b0, c[2:0], 12'h000});
      acc(1'b1, OFF_MODE_CTRL, 4'h1, {24'h0, c[0] ? 8'h40 : 8'h80});
      stop_exec = 1'b1;
      wt(1'b0);
      `CHK("lp mode", c[0] ? PCG_MODE_DOZE : PCG_MODE_WAIT, lp_mode)
      irq_level = thr;
      repeat (6) @(negedge i_ref_clk);
      `CHK("core clk", 1'b0, core_clk_en)
      irq_level = thr + 3'h1;
      wt(1'b1);
      `CHK("core clk", 1'b1, core_clk_en)
      `CHK("lp mode", PCG_MODE_RUN, lp_mode)
      stop_exec = 1'b0;
      irq_level = 3'h0;
      repeat (3) @(negedge i_ref_clk);
    end
    $display("wake level test done");
    acc(1'b1, OFF_MODE_CTRL, 4'h1, 32'h0);
    stop_exec = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    `CHK("core clk", 1'b1, core_clk_en)
    stop_exec = 1'b0;
    acc(1'b1, OFF_MODE_CTRL, 4'h1, 32'h0000_00C0);
    acc(1'b1, OFF_WAKE_CTRL, 4'h2, 32'h0);
    stop_exec = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    `CHK("core clk", 1'b1, core_clk_en)
    stop_exec = 1'b0;
    acc(1'b1, OFF_WAKE_CTRL, 4'h2, 32'h0000_8000);
    stop_exec = 1'b1;
    wt(1'b0);
    `CHK("lp mode", PCG_MODE_STOP, lp_mode)
    irq_level = 3'h7;
    repeat (6) @(negedge i_ref_clk);
    `CHK("core clk", 1'b0, core_clk_en)
    `CHK("host core clk", 1'b0, host_core_en)
    irq_fixed = 1'b1;
    wt(1'b1);
    `CHK("core clk", 1'b1, core_clk_en)
    stop_exec = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    `CHK("exit pulses", 9, exit_cnt)
    `CHK("exit seen", 9, seen_cnt)
    $display("stop test done");
    give_verdict();
  end
endmodule
